//--- core/vpic_pkg.sv
package vpic_pkg;
    localparam int unsigned NSRC = 32;
    localparam int unsigned STACK_DEPTH = 8;
    // register byte addresses on the wishbone bus
    localparam logic [31:0] ADDR_SMR_BASE = 32'hfffff000;
    localparam logic [31:0] ADDR_SVR_BASE = 32'hfffff080;
    localparam logic [31:0] ADDR_IVR = 32'hfffff100;
    localparam logic [31:0] ADDR_CUR = 32'hfffff108;
    localparam logic [31:0] ADDR_IPR = 32'hfffff10c;
    localparam logic [31:0] ADDR_IMR = 32'hfffff110;
    localparam logic [31:0] ADDR_LINES = 32'hfffff114;
    localparam logic [31:0] ADDR_IECR = 32'hfffff120;
    localparam logic [31:0] ADDR_IDCR = 32'hfffff124;
    localparam logic [31:0] ADDR_ICCR = 32'hfffff128;
    localparam logic [31:0] ADDR_ISCR = 32'hfffff12c;
    localparam logic [31:0] ADDR_EOSCR = 32'hfffff130;
    localparam logic [31:0] ADDR_SPUR = 32'hfffff134;
    localparam logic [31:0] ADDR_FFER = 32'hfffff140;
    localparam logic [31:0] ADDR_FFDR = 32'hfffff144;
    localparam logic [31:0] ADDR_FFSR = 32'hfffff148;
    localparam logic [24:0] ADDR_SMR_PAGE = 25'h1ffffe0;
    localparam logic [24:0] ADDR_SVR_PAGE = 25'h1ffffe1;
    // source mode register layout
    localparam int unsigned SMR_PRIO_LSB = 0;
    localparam int unsigned SMR_TYPE_LSB = 5;
    localparam logic [2:0] PRIO_RESET = 3'h0;
    localparam logic [1:0] TYPE_RESET = 2'h0;
    // type bit 0: edge, bit 1: low level / falling edge (external only)
    localparam int unsigned TYPE_EDGE_BIT = 0;
    localparam int unsigned TYPE_NEG_BIT = 1;
    localparam logic [31:0] EXT_SRC_MASK = 32'he0000001;
    localparam logic [31:0] NORMAL_SRC_MASK = 32'hfffffffe;
    localparam logic [31:0] FAST_SRC0 = 32'h00000001;
    localparam logic [31:0] SPUR_RESET = 32'h00000000;
    localparam logic [3:0] DEPTH_EMPTY = 4'h0;
    localparam logic [3:0] DEPTH_FULL = 4'h8;
endpackage

//--- core/vpic_mem_if.sv
interface vpic_mem_if;
    logic wr_en;
    logic [4:0] wr_idx;
    logic [3:0] wr_be;
    logic [31:0] wr_data;
    logic [4:0] rd_idx;
    logic [31:0] rd_data;
    modport mem (input wr_en, input wr_idx, input wr_be, input wr_data, input rd_idx,
        output rd_data);
    modport ctl (output wr_en, output wr_idx, output wr_be, output wr_data, output rd_idx,
        input rd_data);
endinterface

//--- core/vpic_vec_mem.sv
module vpic_vec_mem
    import vpic_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    vpic_mem_if.mem port
);
    typedef struct packed {
        logic [31:0] rd_data;
    } vpic_mem_s;

    vpic_mem_s st;
    vpic_mem_s next_st;
    logic [31:0] store [NSRC];

    // one handler address per source, byte lanes written separately
    always_ff @(posedge clk) begin
        for (int b = 0; b < 4; b++) begin
            if (port.wr_en && port.wr_be[b]) begin
                store[port.wr_idx][8*b +: 8] <= port.wr_data[8*b +: 8];
            end
        end
    end

    always_comb begin
        next_st = st;
        next_st.rd_data = store[port.rd_idx];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign port.rd_data = st.rd_data;
endmodule // vpic_vec_mem

//--- core/vpic_ctrl.sv
// What this block does
// (RULE1) irq line resolves sources 1-31, not forced
// (RULE2) per-source three-bit priority, seven highest
// (RULE3) enabled condition asserts irq line promptly
// (RULE4) current interrupt chosen at vector read
// (RULE5) equal priority: lowest source number wins
// (RULE6) during service only higher priority asserts
// (RULE7) vector read pushes number and level
// (RULE8) nesting stack holds eight entries
// (RULE9) vector read returns source handler address
// (RULE10) vector read register at fixed address
// (RULE11) vector read deasserts irq; software must read
// (RULE12) vector read clears edge-triggered current source
// (RULE13) end-of-service write pops the stack
// (RULE14) after pop, higher than new level reasserts
// (RULE15) software clears level causes at peripheral
// (RULE16) software masks core before end-of-service
// (RULE17) only source 0 or forced raise fast
// (RULE18) type selects level/edge and polarity
// (RULE19) forced sources excluded from normal resolution
// (RULE20) vector read never clears forced sources
// (RULE21) reset: empty stack, irq line high
//
// Added by the designer: the Wishbone register port.
module vpic_ctrl
    import vpic_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [31:0] irq_src,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic normal_irq_out_n,
    output logic fast_irq_out_n
);
    typedef struct packed {
        logic ack;
        logic mem_sel;
        logic [31:0] rdat;
        logic [31:0] prev;
        logic [31:0] edge_pend;
        logic [31:0] imr;
        logic [31:0] ffsr;
        logic [31:0][2:0] priority_field;
        logic [31:0][1:0] source_type_field;
        logic [3:0] depth;
        logic [7:0][7:0] stk;
        logic [31:0] spur;
    } vpic_state_s;

    vpic_state_s st;
    vpic_state_s next_st;
    vpic_mem_if vmem();

    // returns {valid, number, priority} of the best eligible normal source
    function automatic logic [8:0] vpic_resolve(input logic [31:0] elig,
                                                input logic [31:0][2:0] prio);
        logic [8:0] r;
        r = 9'h000;
        for (int i = NSRC - 1; i >= 1; i--) begin
            if (elig[i] && (!r[8] || prio[i] >= r[2:0])) begin // [RULE2] [RULE5]
                r = {1'b1, 5'(i), prio[i]};
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] vpic_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] is_edge;
    logic [31:0] lvl_act;
    logic [31:0] det;
    logic [31:0] pend;
    logic [31:0] elig;
    logic [8:0] cand;
    logic cand_valid;
    logic [4:0] cand_num;
    logic [2:0] cand_prio;
    logic [2:0] cur_lvl;
    logic [4:0] cur_num;
    logic [2:0] top_idx;
    logic irq_act;
    logic fiq_act;
    logic req;
    logic acc;
    logic ivr_rd;
    logic eos_wr;
    logic [31:0] clr_m;
    logic [31:0] set_m;

    // per-source input condition
    for (genvar i = 0; i < NSRC; i++) begin : g_src
        logic neg;
        assign neg = EXT_SRC_MASK[i] & st.source_type_field[i][TYPE_NEG_BIT];
        assign is_edge[i] = st.source_type_field[i][TYPE_EDGE_BIT]; // [RULE18]
        assign lvl_act[i] = neg ? !irq_src[i] : irq_src[i]; // [RULE18]
        assign det[i] = is_edge[i] && (neg ? (st.prev[i] && !irq_src[i])
                                           : (!st.prev[i] && irq_src[i])); // [RULE18]
        assign pend[i] = is_edge[i] ? st.edge_pend[i] : lvl_act[i];
    end

    assign elig = pend & st.imr & NORMAL_SRC_MASK & ~st.ffsr; // [RULE1] [RULE19]
    assign cand = vpic_resolve(elig, st.priority_field);
    assign cand_valid = cand[8];
    assign cand_num = cand[7:3];
    assign cand_prio = cand[2:0];
    assign top_idx = 3'(st.depth - 4'h1);
    assign cur_lvl = st.stk[top_idx][2:0];
    assign cur_num = (st.depth == DEPTH_EMPTY) ? 5'h00 : st.stk[top_idx][7:3];
    // empty stack means no current level; otherwise strictly higher only
    assign irq_act = cand_valid && ((st.depth == DEPTH_EMPTY) || (cand_prio > cur_lvl)); // [RULE3] [RULE6] [RULE14]
    assign fiq_act = |(pend & st.imr & (st.ffsr | FAST_SRC0)); // [RULE17] [RULE19]
    assign normal_irq_out_n = !irq_act; // [RULE21]
    assign fast_irq_out_n = !fiq_act;

    assign req = wb_cyc_i && wb_stb_i;
    assign acc = req && !st.ack;
    assign ivr_rd = acc && !wb_we_i && (wb_adr_i == ADDR_IVR); // [RULE10]
    assign eos_wr = acc && wb_we_i && (wb_adr_i == ADDR_EOSCR) && (|wb_sel_i);

    assign vmem.wr_en = acc && wb_we_i && (wb_adr_i[31:7] == ADDR_SVR_PAGE);
    assign vmem.wr_idx = wb_adr_i[6:2];
    assign vmem.wr_be = wb_sel_i;
    assign vmem.wr_data = wb_dat_i;
    assign vmem.rd_idx = ivr_rd ? cand_num : wb_adr_i[6:2]; // [RULE4] [RULE9]

    vpic_vec_mem u_vec_mem (
        .clk(clk),
        .resetn(resetn),
        .port(vmem.mem)
    );

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.mem_sel ? vmem.rd_data : st.rdat;

    always_comb begin
        next_st = st;
        clr_m = 32'h00000000;
        set_m = 32'h00000000;
        next_st.ack = acc;
        next_st.prev = irq_src;
        if (acc && wb_we_i) begin
            if (wb_adr_i[31:7] == ADDR_SMR_PAGE && wb_sel_i[0]) begin
                next_st.priority_field[wb_adr_i[6:2]] = wb_dat_i[SMR_PRIO_LSB +: 3]; // [RULE2]
                next_st.source_type_field[wb_adr_i[6:2]] = wb_dat_i[SMR_TYPE_LSB +: 2]; // [RULE18]
            end
            case (wb_adr_i)
                ADDR_IECR: next_st.imr = st.imr | wb_dat_i;
                ADDR_IDCR: next_st.imr = st.imr & ~wb_dat_i;
                ADDR_ICCR: clr_m = wb_dat_i;
                ADDR_ISCR: set_m = wb_dat_i;
                ADDR_FFER: next_st.ffsr = st.ffsr | (wb_dat_i & NORMAL_SRC_MASK);
                ADDR_FFDR: next_st.ffsr = st.ffsr & ~wb_dat_i;
                ADDR_SPUR: next_st.spur = vpic_merge(st.spur, wb_dat_i, wb_sel_i);
                default: next_st.spur = st.spur;
            endcase
        end
        if (acc && !wb_we_i) begin
            next_st.mem_sel = (wb_adr_i[31:7] == ADDR_SVR_PAGE);
            next_st.rdat = 32'h00000000;
            if (wb_adr_i[31:7] == ADDR_SMR_PAGE) begin
                next_st.rdat[SMR_PRIO_LSB +: 3] = st.priority_field[wb_adr_i[6:2]];
                next_st.rdat[SMR_TYPE_LSB +: 2] = st.source_type_field[wb_adr_i[6:2]];
            end
            case (wb_adr_i)
                ADDR_IVR: begin
                    next_st.mem_sel = cand_valid; // [RULE9]
                    next_st.rdat = st.spur;
                end
                ADDR_CUR: next_st.rdat = {27'h0000000, cur_num};
                ADDR_IPR: next_st.rdat = pend;
                ADDR_IMR: next_st.rdat = st.imr;
                ADDR_LINES: next_st.rdat = {30'h00000000, fiq_act, irq_act};
                ADDR_SPUR: next_st.rdat = st.spur;
                ADDR_FFSR: next_st.rdat = st.ffsr;
                default: next_st.rdat = next_st.rdat;
            endcase
        end
        if (ivr_rd && cand_valid) begin
            // forced sources never become candidates, so they are never cleared here
            clr_m[cand_num] = 1'b1; // [RULE12] [RULE20]
            if (st.depth != DEPTH_FULL) begin
                next_st.stk[st.depth[2:0]] = {cand_num, cand_prio}; // [RULE7] [RULE4]
                next_st.depth = st.depth + 4'h1; // [RULE8]
            end
        end else if (eos_wr && st.depth != DEPTH_EMPTY) begin
            next_st.depth = st.depth - 4'h1; // [RULE13]
        end
        // a new edge wins over any clear in the same cycle
        next_st.edge_pend = (det | set_m | (st.edge_pend & ~clr_m)) & is_edge;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            next_st_reset: begin
                st.ack <= 1'b0;
                st.mem_sel <= 1'b0;
                st.rdat <= 32'h00000000;
                st.prev <= 32'h00000000;
                st.edge_pend <= 32'h00000000;
                st.imr <= 32'h00000000;
                st.ffsr <= 32'h00000000;
                st.priority_field <= {NSRC{PRIO_RESET}};
                st.source_type_field <= {NSRC{TYPE_RESET}};
                st.depth <= DEPTH_EMPTY; // [RULE21]
                st.stk <= '0;
                st.spur <= SPUR_RESET;
            end
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_res_range;
        cand_valid |-> (cand_num != 5'h00) && !st.ffsr[cand_num] && st.imr[cand_num];
    endproperty
    a_res_range: assert property (p_res_range) else $error("resolver picked bad source"); // [RULE1]

    property p_idle_assert;
        (st.depth == DEPTH_EMPTY) && (|elig) |-> !normal_irq_out_n;
    endproperty
    a_idle_assert: assert property (p_idle_assert) else $error("irq line not asserted"); // [RULE3]

    property p_nest_block;
        (st.depth != DEPTH_EMPTY) && cand_valid && (cand_prio <= cur_lvl) |-> normal_irq_out_n;
    endproperty
    a_nest_block: assert property (p_nest_block) else $error("irq asserted at level"); // [RULE6]

    property p_push;
        ivr_rd && cand_valid && (st.depth != DEPTH_FULL) |=>
            (st.depth == $past(st.depth) + 4'h1) && (st.stk[top_idx] == $past({cand_num, cand_prio}));
    endproperty
    a_push: assert property (p_push) else $error("vector read did not push"); // [RULE7]

    property p_depth_cap;
        st.depth <= DEPTH_FULL;
    endproperty
    a_depth_cap: assert property (p_depth_cap) else $error("stack overflow"); // [RULE8]

    property p_read_deassert;
        ivr_rd && cand_valid ##1 !(cand_valid && cand_prio > cur_lvl) |-> normal_irq_out_n;
    endproperty
    a_read_deassert: assert property (p_read_deassert) else $error("irq stays after read"); // [RULE11]

    property p_edge_clear;
        ivr_rd && cand_valid && is_edge[cand_num] && !det[cand_num] |=>
            !st.edge_pend[$past(cand_num)];
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("edge pending not cleared"); // [RULE12]

    property p_pop;
        eos_wr && !ivr_rd && (st.depth != DEPTH_EMPTY) |=> st.depth == $past(st.depth) - 4'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("end of service did not pop"); // [RULE13]

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles"); // [RULE10]
endmodule // vpic_ctrl

//--- testbench/vpic_core_model.sv
module vpic_core_model
    import vpic_pkg::*;
(
    input wire logic clk,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    output logic [31:0] wb_adr_i,
    output logic [31:0] wb_dat_i,
    output logic [3:0] wb_sel_i,
    output logic wb_we_i,
    output logic wb_cyc_i,
    output logic wb_stb_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic core_masked;
    initial begin
        wb_adr_i = 32'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'hf;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        core_masked = 1'b1;
    end
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask
    // handler entry: vector read even if unused
    task automatic enter(output logic [31:0] v);
        core_masked = 1'b0;
        rd(32'hfffff100, v);
    endtask
    // handler exit: mask at the core first
    task automatic leave();
        core_masked = 1'b1;
        wr(ADDR_EOSCR, 32'h0);
    endtask
endmodule // vpic_core_model

//--- testbench/vpic_ctrl_test.sv
module vpic_ctrl_test
    import vpic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [31:0] irq_src = 32'h0;
    logic [31:0] adr, wdat, rdat, q;
    logic [3:0] sel;
    logic we, cyc, stb, ack, irq_n, fiq_n;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    vpic_ctrl vpic_ctrl_inst (.clk(clk), .resetn(resetn), .irq_src(irq_src), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(rdat), .wb_ack_o(ack), .normal_irq_out_n(irq_n), .fast_irq_out_n(fiq_n));
    vpic_core_model core_inst (.clk(clk), .wb_ack_o(ack), .wb_dat_o(rdat), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cfg(input int n, input logic [31:0] mode);
        core_inst.wr(ADDR_SMR_BASE + 32'(n * 4), mode);
        core_inst.wr(ADDR_SVR_BASE + 32'(n * 4), 32'h1000 + 32'(n));
        core_inst.wr(ADDR_IECR, 32'h1 << n);
    endtask
    task automatic drv(input int n, input logic v);
        @(posedge clk);
        irq_src[n] <= v;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_reset();
        check("irq", {31'h0, irq_n}, 32'h1);
        check("fiq", {31'h0, fiq_n}, 32'h1);
        core_inst.rd(ADDR_IVR, q);
        check("spur", q, SPUR_RESET);
        core_inst.rd(ADDR_CUR, q);
        check("cur", q, 32'h0);
        core_inst.rd(32'hfffff1fc, q);
        check("unmapped", q, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_prio();
        cfg(3, 32'h2);
        cfg(5, 32'h5);
        cfg(9, 32'h5);
        drv(3, 1'b1);
        check("irq", {31'h0, irq_n}, 32'h0);
        core_inst.enter(q);
        check("vec3", q, 32'h1003);
        check("irq", {31'h0, irq_n}, 32'h1);
        drv(9, 1'b1);
        drv(5, 1'b1);
        check("irq", {31'h0, irq_n}, 32'h0);
        core_inst.enter(q);
        check("vec5", q, 32'h1005);
        check("irq", {31'h0, irq_n}, 32'h1);
        drv(5, 1'b0);
        core_inst.leave();
        check("irq", {31'h0, irq_n}, 32'h0);
        core_inst.rd(ADDR_CUR, q);
        check("cur", q, 32'h3);
        core_inst.enter(q);
        check("vec9", q, 32'h1009);
        drv(9, 1'b0);
        core_inst.leave();
        check("irq", {31'h0, irq_n}, 32'h1);
        drv(3, 1'b0);
        core_inst.leave();
        core_inst.rd(ADDR_CUR, q);
        check("cur", q, 32'h0);
        $display("priority test done");
    endtask
    task automatic t_edge();
        cfg(4, 32'h21);
        drv(4, 1'b1);
        drv(4, 1'b0);
        check("irq", {31'h0, irq_n}, 32'h0);
        core_inst.enter(q);
        check("vec4", q, 32'h1004);
        core_inst.rd(ADDR_IPR, q);
        check("ipr4", {31'h0, q[4]}, 32'h0);
        core_inst.leave();
        check("irq", {31'h0, irq_n}, 32'h1);
        $display("edge test done");
    endtask
    task automatic t_fast();
        cfg(6, 32'h27);
        core_inst.wr(ADDR_FFER, 32'h40);
        core_inst.wr(ADDR_SPUR, 32'h0000beef);
        drv(6, 1'b1);
        drv(6, 1'b0);
        check("irq", {31'h0, irq_n}, 32'h1);
        check("fiq", {31'h0, fiq_n}, 32'h0);
        core_inst.rd(ADDR_IVR, q);
        check("spur", q, 32'h0000beef);
        core_inst.rd(ADDR_IPR, q);
        check("ipr6", {31'h0, q[6]}, 32'h1);
        core_inst.wr(ADDR_ICCR, 32'h40);
        core_inst.wr(ADDR_FFDR, 32'h40);
        check("fiq", {31'h0, fiq_n}, 32'h1);
        cfg(0, 32'h0);
        drv(0, 1'b1);
        check("fiq0", {31'h0, fiq_n}, 32'h0);
        check("irq0", {31'h0, irq_n}, 32'h1);
        drv(0, 1'b0);
        $display("fast test done");
    endtask
    task automatic t_polar();
        cfg(30, 32'h64);
        drv(30, 1'b1);
        check("irq30r", {31'h0, irq_n}, 32'h1);
        drv(30, 1'b0);
        check("irq30f", {31'h0, irq_n}, 32'h0);
        core_inst.enter(q);
        check("vec30", q, 32'h101e);
        core_inst.leave();
        check("irq", {31'h0, irq_n}, 32'h1);
        cfg(29, 32'h43);
        check("irq29", {31'h0, irq_n}, 32'h0);
        core_inst.enter(q);
        check("vec29", q, 32'h101d);
        check("irq", {31'h0, irq_n}, 32'h1);
        drv(29, 1'b1);
        core_inst.leave();
        check("irq", {31'h0, irq_n}, 32'h1);
        $display("polarity test done");
    endtask
    task automatic t_depth();
        for (int i = 0; i < 8; i++) cfg(10 + i, 32'(i));
        for (int i = 0; i < 8; i++) begin
            drv(10 + i, 1'b1);
            check("irq", {31'h0, irq_n}, 32'h0);
            core_inst.enter(q);
            check("vecn", q, 32'h100a + 32'(i));
        end
        for (int i = 7; i >= 0; i--) begin
            drv(10 + i, 1'b0);
            core_inst.leave();
            core_inst.rd(ADDR_CUR, q);
            check("cur", q, (i > 0) ? 32'(9 + i) : 32'h0);
        end
        $display("depth test done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_prio();
        t_edge();
        t_fast();
        t_polar();
        t_depth();
        report_and_stop();
    end
endmodule // vpic_ctrl_test
